// >>> core/tx_descriptor_command_status.sv
// tx extended data descriptor: command decode, status writeback, irq delay
// Notes on behaviour
// - writeback with report and delay loads countdown from interval field
// - any delayed-irq descriptor reloads the countdown, even while running
// - countdown reaching zero raises tx interrupt if enabled
// - report without delay raises tx interrupt in the same cycle as writeback
// - an immediate interrupt clears the delay countdown
// - vlan insert adds ethertype and tag from special field
// - with vlan insert, ethertype from register and fcs always appended
// - without vlan insert, untagged frame, fcs only if requested
// - security encap inserts tag header and digest per enable field
// - security encap with security disabled drops the packet
// - status reported once the buffer is fetched into packet buffer
// - device may write status even without report request; this design writes status only on report request
// - status word written back only when report is requested
// - written status sets descriptor done in bit 0
// - segmentation bit marks descriptor as part of segmentation context
// - fcs insert bit decides fcs on a normal frame
// - vlan, fcs, tag taken from first seg descriptor or last descriptor
// - last flag marks final data of packet or segmentation context
// - length mismatch on last seg descriptor ends context, counts failure
module tx_descriptor_command_status
    import tx_desc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone classic slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // descriptor fetched from host memory
    input wire logic desc_valid_i,
    input wire logic [7:0] command_byte_i,
    input wire logic [3:0] descriptor_type_i,
    input wire logic [15:0] vlan_special_i,
    input wire logic [15:0] buffer_length_i,
    input wire logic [15:0] seg_remaining_i,
    // buffer fetched into the internal packet buffer
    input wire logic buffer_fetched_i,
    // decoded per-packet controls
    output logic pkt_ctrl_valid_o,
    output logic vlan_tag_insert_o,
    output logic [15:0] vlan_ethertype_o,
    output logic [15:0] vlan_tag_o,
    output logic fcs_insert_o,
    output logic security_encap_o,
    output logic [1:0] security_mode_o,
    output logic segmentation_member_o,
    output logic packet_last_flag_o,
    output logic packet_drop_o,
    output logic seg_abort_o,
    output logic format_error_o,
    // status writeback
    output logic wb_valid_o,
    output logic [3:0] status_nibble_o,
    // transmit interrupt
    output logic tx_irq_o
);
    // ==================================================================
    // registers
    // ==================================================================
    logic global_vlan_mode_enable_r;
    logic tx_irq_enable_r;
    logic [15:0] irq_delay_interval_r;
    logic [15:0] vlan_ethertype_r;
    logic [1:0] tx_security_enable_r;
    logic [15:0] seg_context_fail_counter_r;
    logic [15:0] countdown_r;
    logic [6:0] tick_r;
    logic [7:0] cmd_r;
    logic held_r;
    logic seg_first_r;
    logic [31:0] rd_nxt;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FETCH = 2'b01,
        ST_WRITE = 2'b11
    } desc_state_e;
    desc_state_e state_r;

    function automatic logic bus_write(input logic [7:0] a);
        bus_write = cyc_i && stb_i && we_i && !ack_o && adr_i == a;
    endfunction

    // ==================================================================
    // wishbone slave: one wait state, ack for one cycle
    // ==================================================================
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_o <= 1'b0;
        else
            ack_o <= cyc_i && stb_i && !ack_o;
    end

    always_comb
    begin
        unique case (adr_i)
            ADDR_CTRL: rd_nxt = {30'h0, tx_irq_enable_r,
                global_vlan_mode_enable_r};
            ADDR_IRQ_DELAY: rd_nxt = {16'h0, irq_delay_interval_r};
            ADDR_VLAN_TYPE: rd_nxt = {16'h0, vlan_ethertype_r};
            ADDR_SEC_CTRL: rd_nxt = {30'h0, tx_security_enable_r};
            ADDR_STATUS: rd_nxt = {29'h0, tx_irq_o, held_r,
                segmentation_member_o};
            ADDR_FAIL_CNT: rd_nxt = {16'h0, seg_context_fail_counter_r};
            ADDR_COUNTDOWN: rd_nxt = {16'h0, countdown_r};
            default: rd_nxt = UNMAPPED_DATA;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_o <= UNMAPPED_DATA;
        else if (cyc_i && stb_i && !we_i && !ack_o)
            dat_o <= rd_nxt;
    end

    // byte lane 0 carries flag fields; lanes 0-1 carry 16-bit fields
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            global_vlan_mode_enable_r <= 1'b0;
            tx_irq_enable_r <= 1'b0;
            tx_security_enable_r <= SEC_DISABLED;
        end
        else
        begin
            if (bus_write(ADDR_CTRL) && sel_i[0])
            begin
                global_vlan_mode_enable_r <= dat_i[GLOBAL_VLAN_MODE_ENABLE_BIT];
                tx_irq_enable_r <= dat_i[CTRL_TXIRQ_EN_BIT];
            end
            if (bus_write(ADDR_SEC_CTRL) && sel_i[0])
                tx_security_enable_r <= dat_i[SEC_EN_LSB +: 2];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_delay_interval_r <= IRQ_DELAY_RST;
            vlan_ethertype_r <= VLAN_TYPE_RST;
        end
        else
        begin
            if (bus_write(ADDR_IRQ_DELAY))
            begin
                if (sel_i[0])
                    irq_delay_interval_r[7:0] <= dat_i[7:0];
                if (sel_i[1])
                    irq_delay_interval_r[15:8] <= dat_i[15:8];
            end
            if (bus_write(ADDR_VLAN_TYPE))
            begin
                if (sel_i[0])
                    vlan_ethertype_r[7:0] <= dat_i[7:0];
                if (sel_i[1])
                    vlan_ethertype_r[15:8] <= dat_i[15:8];
            end
        end
    end

    // ==================================================================
    // descriptor sequencing
    // ==================================================================
    // the command byte is captured whole on arrival so everything after
    // follows from this descriptor alone
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_r <= ST_IDLE;
            cmd_r <= 8'h00;
            held_r <= 1'b0;
        end
        else
        begin
            unique case (state_r)
                ST_IDLE:
                    if (desc_valid_i)
                    begin
                        cmd_r <= command_byte_i;
                        held_r <= 1'b1;
                        state_r <= ST_FETCH;
                    end
                ST_FETCH:
                    if (buffer_fetched_i)
                        state_r <= ST_WRITE;
                ST_WRITE:
                begin
                    held_r <= 1'b0;
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ==================================================================
    // per-packet control decode
    // ==================================================================
    // fields honoured from first segmentation descriptor or from last
    // descriptor of a normal packet; other descriptors leave them alone
    logic cmd_seg;
    logic cmd_last;
    logic take_fields;
    logic sec_drop;
    assign cmd_seg = command_byte_i[CMD_SEG_MEMBER];
    assign cmd_last = command_byte_i[CMD_PKT_LAST];
    assign take_fields = cmd_seg ? seg_first_r : cmd_last;
    assign sec_drop = command_byte_i[CMD_SEC_ENCAP]
        && tx_security_enable_r == SEC_DISABLED;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            seg_first_r <= 1'b1;
        else if (state_r == ST_IDLE && desc_valid_i)
            seg_first_r <= !cmd_seg || cmd_last;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pkt_ctrl_valid_o <= 1'b0;
            vlan_tag_insert_o <= 1'b0;
            vlan_ethertype_o <= VLAN_TYPE_RST;
            vlan_tag_o <= 16'h0000;
            fcs_insert_o <= 1'b0;
            security_encap_o <= 1'b0;
            security_mode_o <= SEC_DISABLED;
            segmentation_member_o <= 1'b0;
            packet_last_flag_o <= 1'b0;
            packet_drop_o <= 1'b0;
            seg_abort_o <= 1'b0;
            format_error_o <= 1'b0;
        end
        else
        begin
            pkt_ctrl_valid_o <= state_r == ST_IDLE && desc_valid_i;
            packet_drop_o <= 1'b0;
            seg_abort_o <= 1'b0;
            format_error_o <= 1'b0;
            if (state_r == ST_IDLE && desc_valid_i)
            begin
                // flag descriptors not built as extended data type
                format_error_o <= !command_byte_i[CMD_EXT_FORMAT]
                    || descriptor_type_i != DTYPE_DATA;
                segmentation_member_o <= cmd_seg;
                packet_last_flag_o <= cmd_last;
                security_encap_o <= command_byte_i[CMD_SEC_ENCAP];
                security_mode_o <= tx_security_enable_r;
                packet_drop_o <= sec_drop;
                seg_abort_o <= cmd_seg && cmd_last
                    && buffer_length_i != seg_remaining_i;
                if (take_fields)
                begin
                    vlan_tag_insert_o <=
                        command_byte_i[CMD_VLAN_INSERT];
                    vlan_ethertype_o <= vlan_ethertype_r;
                    vlan_tag_o <= vlan_special_i;
                    // vlan tagging forces fcs regardless of the request
                    fcs_insert_o <= command_byte_i[CMD_VLAN_INSERT]
                        || command_byte_i[CMD_FCS_INSERT];
                end
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            seg_context_fail_counter_r <= 16'h0000;
        else if (seg_abort_o)
            seg_context_fail_counter_r <=
                seg_context_fail_counter_r + 16'h0001;
    end

    // ==================================================================
    // status writeback
    // ==================================================================
    // only report-status descriptors are written back; the optional
    // extra writebacks are never used
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_valid_o <= 1'b0;
            status_nibble_o <= 4'h0;
        end
        else
        begin
            wb_valid_o <= state_r == ST_WRITE
                && cmd_r[CMD_REPORT_STATUS];
            status_nibble_o <= STA_DONE;
        end
    end

    // ==================================================================
    // interrupt delay countdown
    // ==================================================================
    logic wb_now;
    logic delayed;
    logic expire;
    assign wb_now = state_r == ST_WRITE;
    assign delayed = cmd_r[CMD_DELAYED_IRQ];
    assign expire = countdown_r == 16'h0001 && tick_r == TICK_LAST;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            countdown_r <= 16'h0000;
            tick_r <= 7'h00;
        end
        else if (wb_now && delayed)
        begin
            // reload even when a previous count is still running
            countdown_r <= irq_delay_interval_r;
            tick_r <= 7'h00;
        end
        else if (wb_now && cmd_r[CMD_REPORT_STATUS])
        begin
            countdown_r <= 16'h0000;
            tick_r <= 7'h00;
        end
        else if (countdown_r != 16'h0000)
        begin
            tick_r <= tick_r == TICK_LAST ? 7'h00 : tick_r + 7'h01;
            if (tick_r == TICK_LAST)
                countdown_r <= countdown_r - 16'h0001;
        end
    end

    // zero interval with report and delay fires at once; limitation: one-cycle pulse
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            tx_irq_o <= 1'b0;
        else
            tx_irq_o <= tx_irq_enable_r && (expire
                || (wb_now && cmd_r[CMD_REPORT_STATUS]
                    && (!delayed || irq_delay_interval_r == 16'h0000)));
    end
endmodule

// >>> core/tx_desc_pkg.sv
// package: command byte layout, status layout, register map, timing
package tx_desc_pkg;
    // command byte bit positions
    localparam int CMD_PKT_LAST = 0;
    localparam int CMD_FCS_INSERT = 1;
    localparam int CMD_SEG_MEMBER = 2;
    localparam int CMD_REPORT_STATUS = 3;
    localparam int CMD_SEC_ENCAP = 4;
    localparam int CMD_EXT_FORMAT = 5;
    localparam int CMD_VLAN_INSERT = 6;
    localparam int CMD_DELAYED_IRQ = 7;
    // descriptor type code for extended data descriptors
    localparam logic [3:0] DTYPE_DATA = 4'h1;
    // status nibble
    localparam int STA_DONE_BIT = 0;
    localparam logic [3:0] STA_DONE = 4'h1;
    // security enable field value meaning disabled
    localparam logic [1:0] SEC_DISABLED = 2'h0;
    // wishbone register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_IRQ_DELAY = 8'h04;
    localparam logic [7:0] ADDR_VLAN_TYPE = 8'h08;
    localparam logic [7:0] ADDR_SEC_CTRL = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_FAIL_CNT = 8'h14;
    localparam logic [7:0] ADDR_COUNTDOWN = 8'h18;
    // control register fields
    localparam int GLOBAL_VLAN_MODE_ENABLE_BIT = 0;
    localparam int CTRL_TXIRQ_EN_BIT = 1;
    localparam int SEC_EN_LSB = 0;
    // reset values
    localparam logic [15:0] VLAN_TYPE_RST = 16'h8100;
    localparam logic [15:0] IRQ_DELAY_RST = 16'h0000;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
    // countdown tick: one unit of the interval is 102 cycles of 10 ns, 1020 ns
    localparam int TICK_NS = 1024;
    localparam int CLK_NS = 10;
    localparam int TICK_CYCLES = TICK_NS / CLK_NS;
    localparam logic [6:0] TICK_LAST = 7'(TICK_CYCLES - 1);
endpackage

// >>> verification/tx_desc_monitor.sv
// checker: bus, decode, writeback and interrupt relations at the ports
module tx_desc_monitor
    import tx_desc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic ack_o,
    input wire logic desc_valid_i,
    input wire logic [7:0] command_byte_i,
    input wire logic [15:0] buffer_length_i,
    input wire logic [15:0] seg_remaining_i,
    input wire logic buffer_fetched_i,
    input wire logic pkt_ctrl_valid_o,
    input wire logic vlan_tag_insert_o,
    input wire logic fcs_insert_o,
    input wire logic security_encap_o,
    input wire logic segmentation_member_o,
    input wire logic packet_last_flag_o,
    input wire logic packet_drop_o,
    input wire logic seg_abort_o,
    input wire logic format_error_o,
    input wire logic wb_valid_o,
    input wire logic [3:0] status_nibble_o,
    input wire logic tx_irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ====
    // shadow state
    logic [7:0] cmd_r;
    logic len_ok_r;
    logic en_r;
    logic sec_off_r;
    logic wr;
    assign wr = cyc_i && stb_i && we_i && ack_o && sel_i[0];
    always_ff @(posedge clk_i)
        if (rst_i)
            cmd_r <= 8'h00;
        else if (desc_valid_i)
            cmd_r <= command_byte_i;
    // only read while a decode is reported, so no reset is needed
    always_ff @(posedge clk_i)
        if (desc_valid_i)
            len_ok_r <= buffer_length_i == seg_remaining_i;
    always_ff @(posedge clk_i)
        if (rst_i)
        begin
            en_r <= 1'b0;
            sec_off_r <= 1'b1;
        end
        else if (wr)
        begin
            if (adr_i == ADDR_CTRL)
                en_r <= dat_i[CTRL_TXIRQ_EN_BIT];
            if (adr_i == ADDR_SEC_CTRL)
                sec_off_r <= dat_i[1:0] == SEC_DISABLED;
        end
    // ====
    // properties
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    a_ack_follows: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("no ack one cycle after request");
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    a_decode_cause: assert property (
        pkt_ctrl_valid_o |-> $past(desc_valid_i))
        else $error("decode without descriptor");
    a_member_flags: assert property (
        pkt_ctrl_valid_o |-> segmentation_member_o == cmd_r[CMD_SEG_MEMBER]
        && packet_last_flag_o == cmd_r[CMD_PKT_LAST]
        && security_encap_o == cmd_r[CMD_SEC_ENCAP])
        else $error("member flags wrong");
    a_vlan_fcs: assert property (
        pkt_ctrl_valid_o && vlan_tag_insert_o |-> fcs_insert_o)
        else $error("tagged frame without fcs");
    a_normal_fcs: assert property (
        pkt_ctrl_valid_o && !cmd_r[CMD_SEG_MEMBER] && cmd_r[CMD_PKT_LAST]
        |-> vlan_tag_insert_o == cmd_r[CMD_VLAN_INSERT] && fcs_insert_o ==
        (cmd_r[CMD_FCS_INSERT] || cmd_r[CMD_VLAN_INSERT]))
        else $error("last descriptor decode wrong");
    a_drop_rule: assert property (
        pkt_ctrl_valid_o
        |-> packet_drop_o == (cmd_r[CMD_SEC_ENCAP] && sec_off_r))
        else $error("drop flag wrong");
    a_seg_abort: assert property (
        pkt_ctrl_valid_o |-> seg_abort_o == (cmd_r[CMD_SEG_MEMBER]
        && cmd_r[CMD_PKT_LAST] && !len_ok_r))
        else $error("abort flag wrong");
    a_fetch_to_wb: assert property (
        buffer_fetched_i && cmd_r[CMD_REPORT_STATUS] |-> ##2 wb_valid_o)
        else $error("status not written two cycles after fetch");
    a_wb_needs_rs: assert property (
        wb_valid_o |-> cmd_r[CMD_REPORT_STATUS] && $past(buffer_fetched_i, 2))
        else $error("status written without request");
    a_done_bit: assert property (
        wb_valid_o |-> status_nibble_o == STA_DONE)
        else $error("done bit missing");
    a_pulse_align: assert property (
        packet_drop_o || seg_abort_o || format_error_o |-> pkt_ctrl_valid_o)
        else $error("flag pulse without decode");
    a_imm_irq: assert property (
        wb_valid_o && !cmd_r[CMD_DELAYED_IRQ] && en_r |-> tx_irq_o)
        else $error("no immediate interrupt");
    a_irq_enabled: assert property (tx_irq_o |-> en_r)
        else $error("interrupt while disabled");
    cover property (wb_valid_o && tx_irq_o);
    cover property (seg_abort_o);
    cover property (packet_drop_o);
    cover property (format_error_o);
endmodule

bind tx_descriptor_command_status tx_desc_monitor mon (.*);

// >>> verification/host_desc_model.sv
// host driver model: presents descriptors and buffer fetch events
module host_desc_model
    import tx_desc_pkg::*;
(
    input wire logic clk_i,
    output logic desc_valid_o,
    output logic [7:0] command_byte_o,
    output logic [3:0] descriptor_type_o,
    output logic [15:0] vlan_special_o,
    output logic [15:0] buffer_length_o,
    output logic [15:0] seg_remaining_o,
    output logic buffer_fetched_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // the bench may plant a wrong type code to provoke the format flag
    logic [3:0] type_code = DTYPE_DATA;
    initial
    begin
        desc_valid_o = 1'b0;
        buffer_fetched_o = 1'b0;
        {command_byte_o, descriptor_type_o} = 12'h000;
        {vlan_special_o, buffer_length_o, seg_remaining_o} = 48'h0;
    end
    // stall stretches the gap before the buffer lands
    task automatic send(input logic [7:0] c, input logic [15:0] l,
        input logic [15:0] r, input int stall);
        @(posedge clk_i);
        desc_valid_o <= 1'b1;
        command_byte_o <= c | 8'h20;
        descriptor_type_o <= type_code;
        vlan_special_o <= 16'h5A3C;
        buffer_length_o <= l;
        seg_remaining_o <= r;
        @(posedge clk_i);
        desc_valid_o <= 1'b0;
        // fields mean nothing without the strobe, so command, type and tag do not hold
        command_byte_o <= ~command_byte_o;
        descriptor_type_o <= ~descriptor_type_o;
        vlan_special_o <= ~vlan_special_o;
        repeat (stall) @(posedge clk_i);
        buffer_fetched_o <= 1'b1;
        @(posedge clk_i);
        buffer_fetched_o <= 1'b0;
        repeat (3) @(posedge clk_i);
    endtask
endmodule

// >>> verification/tx_descriptor_command_status_tb.sv
// self-checking bench: decode table, registers, irq delay, reset
module tx_descriptor_command_status_tb
    import tx_desc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o, q;
    logic ack_o, desc_valid_i, buffer_fetched_i, pkt_ctrl_valid_o;
    logic [7:0] command_byte_i;
    logic [3:0] descriptor_type_i, status_nibble_o;
    logic [15:0] vlan_special_i, buffer_length_i, seg_remaining_i;
    logic vlan_tag_insert_o, fcs_insert_o, security_encap_o, wb_valid_o;
    logic segmentation_member_o, packet_last_flag_o, packet_drop_o;
    logic seg_abort_o, format_error_o, tx_irq_o;
    logic [15:0] vlan_ethertype_o, vlan_tag_o;
    logic [1:0] security_mode_o;
    int bad_count = 0, checks = 0, cyc_n = 0, irqs = 0, wbs = 0;
    int drops = 0, aborts = 0, wb_t = 0, irq_t = 0, n0, i0, d0, fmts = 0;
    // cmd, then expected vlan, fcs, drop, writeback
    logic [11:0] rows [7] = '{12'h210, 12'h234, 12'h61C, 12'h63C,
        12'h291, 12'h336, 12'h250};
    always #5 clk_i = ~clk_i;
    tx_descriptor_command_status DUT (.*);
    host_desc_model host (
        .clk_i(clk_i),
        .desc_valid_o(desc_valid_i),
        .command_byte_o(command_byte_i),
        .descriptor_type_o(descriptor_type_i),
        .vlan_special_o(vlan_special_i),
        .buffer_length_o(buffer_length_i),
        .seg_remaining_o(seg_remaining_i),
        .buffer_fetched_o(buffer_fetched_i)
    );
    // ====
    // event tally
    always @(posedge clk_i)
    begin
        cyc_n <= cyc_n + 1;
        wbs <= wbs + (wb_valid_o === 1'b1);
        irqs <= irqs + (tx_irq_o === 1'b1);
        drops <= drops + (packet_drop_o === 1'b1);
        aborts <= aborts + (seg_abort_o === 1'b1);
        fmts <= fmts + (format_error_o === 1'b1);
        if (wb_valid_o === 1'b1)
            wb_t <= cyc_n;
        if (tx_irq_o === 1'b1)
            irq_t <= cyc_n;
    end
    // ====
    // tasks
    task automatic chk(input logic ok, input string m);
        checks++;
        if (ok !== 1'b1)
        begin
            bad_count++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        sel_i <= 4'hF;
        @(posedge clk_i);
        while (ack_o !== 1'b1 && n < 20)
        begin
            @(posedge clk_i);
            n++;
        end
        chk(n < 20, "bus hang");
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wait_irq();
        for (int k = 0; k < 1000 && irqs == i0; k++)
            @(posedge clk_i);
    endtask
    task automatic complete_run();
        $display("mismatches %0d checks %0d", bad_count, checks);
        if (bad_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        #200us;
        $display("BAD %0t watchdog expired", $time);
        bad_count++;
        complete_run();
    end
    // ====
    // main sequence
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1, ADDR_CTRL, 32'h3);
        bus(1, ADDR_IRQ_DELAY, 32'h3);
        for (int i = 0; i < 7; i++)
        begin
            n0 = wbs;
            i0 = irqs;
            d0 = drops;
            host.send(rows[i][11:4], 16'h40, 16'h40, i % 4);
            chk(vlan_tag_insert_o === rows[i][3], "vlan");
            chk(fcs_insert_o === rows[i][2], "fcs");
            chk(drops - d0 == rows[i][1], "drop");
            chk(wbs - n0 == rows[i][0], "writeback");
            chk(irqs - i0 == rows[i][0], "irq now");
            chk(status_nibble_o === STA_DONE, "status");
        end
        bus(1, ADDR_VLAN_TYPE, 32'h88A8);
        host.send(8'h41, 16'h40, 16'h40, 0);
        chk(vlan_ethertype_o === 16'h88A8, "ethertype");
        chk(vlan_tag_o === 16'h5A3C, "tag");
        host.send(8'h05, 16'h40, 16'h30, 2);
        chk(aborts == 1, "abort");
        bus(1, ADDR_FAIL_CNT, 32'h7);
        bus(0, ADDR_FAIL_CNT, 0);
        chk(q === 32'h1, "fail count");
        bus(1, 8'h1C, 32'hFFFF);
        bus(0, 8'h1C, 0);
        chk(q === UNMAPPED_DATA, "unmapped");
        // later segment descriptors must not disturb the first one's fields
        host.send(8'h44, 16'h40, 16'h40, 0);
        host.send(8'h05, 16'h40, 16'h40, 0);
        chk(vlan_tag_insert_o === 1'b1, "seg vlan");
        chk(fcs_insert_o === 1'b1, "seg fcs");
        host.type_code = 4'h3;
        host.send(8'h01, 16'h40, 16'h40, 0);
        host.type_code = DTYPE_DATA;
        chk(fmts == 1, "format");
        bus(1, ADDR_SEC_CTRL, 32'h1);
        d0 = drops;
        host.send(8'h13, 16'h40, 16'h40, 1);
        chk(drops == d0 && security_mode_o === 2'h1, "secure");
        i0 = irqs;
        host.send(8'h89, 16'h40, 16'h40, 0);
        bus(0, ADDR_COUNTDOWN, 0);
        chk(q === 32'h3, "countdown");
        wait_irq();
        chk(irq_t - wb_t > 2 * TICK_CYCLES, "early");
        chk(irq_t - wb_t <= 4 * TICK_CYCLES, "late");
        i0 = irqs;
        host.send(8'h89, 16'h40, 16'h40, 0);
        repeat (150) @(posedge clk_i);
        host.send(8'h89, 16'h40, 16'h40, 5);
        wait_irq();
        chk(irq_t - wb_t > 2 * TICK_CYCLES, "reload");
        i0 = irqs;
        host.send(8'h89, 16'h40, 16'h40, 0);
        host.send(8'h09, 16'h40, 16'h40, 0);
        repeat (500) @(posedge clk_i);
        chk(irqs == i0 + 1, "cleared");
        bus(1, ADDR_CTRL, 32'h1);
        i0 = irqs;
        host.send(8'h09, 16'h40, 16'h40, 0);
        host.send(8'h89, 16'h40, 16'h40, 0);
        repeat (500) @(posedge clk_i);
        chk(irqs == i0, "masked");
        // second reset mid-run must restore the ethertype and delay defaults and clear irq and writeback
        rst_i <= 1'b1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk(vlan_ethertype_o === VLAN_TYPE_RST, "reset type");
        chk(tx_irq_o === 1'b0 && wb_valid_o === 1'b0, "reset out");
        bus(0, ADDR_VLAN_TYPE, 0);
        chk(q === 32'(VLAN_TYPE_RST), "type reg");
        bus(0, ADDR_IRQ_DELAY, 0);
        chk(q === 32'(IRQ_DELAY_RST), "delay reg");
        complete_run();
    end
endmodule
